// ---- core/scis_scheduler.sv ----
// scan interrupt scheduler: pending, priority, nesting and fault handling
// assumes sources pulse for one cycle and the executor reports rung starts
//
// How it works
// - sixteen sources: user fault, eight events, six counters, one timed.
// - only configured and enabled sources are dispatched to a handler.
// - service only at a rung start, during end of scan, or when a handler returns.
// - requests of disabled sources still become pending at next opportunity.
// - dispatch saves the interrupted point, starts at rung 0, resumes there.
// - all pending requests run back to back, highest priority first.
// - a higher request preempts a running lower handler, which then finishes.
// - a lower pending request waits, then runs before normal execution resumes.
// - fixed order fault, ev0, ev1, ctr0, ev2, ev3, ctr1, timed, ev4 ...
// - user faults start the fault handler; non-user faults halt instead.
// - arithmetic flags saved on fault handler entry, restored on exit.
// - fault handler file comes from the selector register, range 3 to 255.
// - a recoverable fault cleared by the handler avoids shutdown.
// - disable mask bits follow the fixed per-source layout, bits 0 to 14.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module scis_scheduler (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        fault_req,
  input  wire logic [1:0]  fault_class,
  input  wire logic        fault_clear,
  input  wire logic [15:0] arith_flags,
  input  wire logic [7:0]  event_input_interrupt,
  input  wire logic [5:0]  fast_counter_interrupt,
  input  wire logic        periodic_timed_interrupt,
  input  wire logic        rung_start,
  input  wire logic        end_of_scan,
  input  wire logic        handler_done,
  input  wire logic [7:0]  cur_file,
  input  wire logic [15:0] cur_rung,
  output logic             jump,
  output logic             jump_resume,
  output logic [3:0]       jump_src,
  output logic [7:0]       jump_file,
  output logic [15:0]      jump_rung,
  output logic             arith_restore,
  output logic [15:0]      arith_value,
  output logic             halted,
  output logic             shutdown,
  output logic             major_fault
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    scis_pkg::scis_state_type st;
    logic [15:0]              arrived;
    logic [15:0]              pending;
    logic [15:0]              cfg;
    logic [15:0]              dis;
    logic [7:0]               ffile;
    logic [4:0]               sp;
    logic [3:0]               cur_pri;
    logic [31:0]              rdata;
    logic [2:0]               irq_st;
    logic [2:0]               irq_en;
    logic [15:0]              saved;
    logic                     major;
    logic                     recov;
    logic                     halted;
    logic                     shutdown;
    logic                     jump;
    logic                     resume;
    logic [3:0]               jsrc;
    logic [7:0]               jfile;
    logic [15:0]              jrung;
    logic                     arest;
    logic [15:0]              aval;
  } scis_regs_type;

  scis_regs_type s;
  scis_regs_type next_s;

  logic [15:0]                 req;
  logic [15:0]                 en;
  logic [15:0]                 cand;
  logic                        win_valid;
  logic [3:0]                  win;
  logic                        opp;
  logic                        svc;
  logic                        push;
  logic [scis_pkg::CTX_W-1:0]  push_data;
  logic [scis_pkg::CTX_W-1:0]  top;
  logic                        wr;
  logic                        rd;
  logic [2:0]                  irq_ev;

  // ----------------------------------------------------------------
  // sources in priority order, bit 0 highest
  // ----------------------------------------------------------------
  assign req = {fast_counter_interrupt[5], event_input_interrupt[7],
                fast_counter_interrupt[4], event_input_interrupt[6],
                fast_counter_interrupt[3], event_input_interrupt[5],
                fast_counter_interrupt[2], event_input_interrupt[4],
                periodic_timed_interrupt, fast_counter_interrupt[1],
                event_input_interrupt[3], event_input_interrupt[2],
                fast_counter_interrupt[0], event_input_interrupt[1],
                event_input_interrupt[0],
                fault_req && (fault_class != scis_pkg::CLASS_NONUSER)};

  assign opp = rung_start || end_of_scan;
  assign svc = opp || (s.st == scis_pkg::ST_POP);

  always_comb begin
    en    = '0;
    en[0] = s.cfg[0] && (s.ffile >= scis_pkg::FFILE_MIN);
    for (int i = 1; i < scis_pkg::NSRC; i++) begin
      en[i] = s.cfg[i] && !s.dis[scis_pkg::scis_mask_bit(4'(i))];
    end
  end

  // pending requests plus those caught since the last opportunity
  assign cand = (s.pending | (opp ? s.arrived : 16'h0000)) & en;

  scis_prio_enc #(
    .N (scis_pkg::NSRC)
  ) u_pick (
    .req   (cand),
    .valid (win_valid),
    .idx   (win)
  );

  scis_ctx_stack #(
    .W     (scis_pkg::CTX_W),
    .DEPTH (scis_pkg::NSRC)
  ) u_stack (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (push),
    .wr_addr (s.sp[3:0]),
    .wr_data (push_data),
    .rd_addr (4'(s.sp - 5'h01)),
    .rd_data (top)
  );

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s        = s;
    next_s.jump   = 1'b0;
    next_s.arest  = 1'b0;
    next_s.resume = 1'b0;
    push          = 1'b0;
    push_data     = {s.cur_pri, cur_file, cur_rung};
    irq_ev        = '0;
    // requests latch now and turn pending at the next opportunity
    next_s.arrived = (opp ? 16'h0000 : s.arrived) | req;
    next_s.pending = s.pending | (opp ? s.arrived : 16'h0000);
    // clear first, so a fault in the same cycle wins
    if (fault_clear && s.recov) begin
      next_s.major = 1'b0;
    end
    if (fault_req && fault_class == scis_pkg::CLASS_NONUSER) begin
      next_s.halted    = 1'b1;
      irq_ev[scis_pkg::IRQ_HALT] = 1'b1;
    end else if (fault_req) begin
      next_s.major = 1'b1;
      next_s.recov = (fault_class == scis_pkg::CLASS_RECOV);
    end
    unique case (s.st)
      scis_pkg::ST_NORMAL, scis_pkg::ST_HANDLER: begin
        if (opp && win_valid && !s.halted && !s.shutdown &&
            (s.sp == 5'h00 || win < s.cur_pri)) begin
          push        = 1'b1;
          next_s.sp   = s.sp + 5'h01;
          next_s.jump = 1'b1;
          next_s.st   = scis_pkg::ST_HANDLER;
        end else if (handler_done && s.st == scis_pkg::ST_HANDLER) begin
          if (s.cur_pri == 4'h0) begin
            next_s.arest = 1'b1;
            next_s.aval  = s.saved;
            if (s.major) begin
              next_s.shutdown = 1'b1;
              irq_ev[scis_pkg::IRQ_SHUTDOWN] = 1'b1;
            end
          end
          next_s.st = scis_pkg::ST_POP;
        end
      end
      scis_pkg::ST_POP: begin
        if (win_valid && !s.halted && !s.shutdown &&
            (s.sp == 5'h01 || win < top[27:24])) begin
          next_s.jump = 1'b1;
          next_s.st   = scis_pkg::ST_HANDLER;
        end else begin
          next_s.sp      = s.sp - 5'h01;
          next_s.cur_pri = top[27:24];
          next_s.jump    = 1'b1;
          next_s.resume  = 1'b1;
          next_s.jsrc    = top[27:24];
          next_s.jfile   = top[23:16];
          next_s.jrung   = top[15:0];
          next_s.st      = (s.sp == 5'h01) ? scis_pkg::ST_NORMAL : scis_pkg::ST_HANDLER;
        end
      end
      default: begin
        next_s.st = scis_pkg::ST_NORMAL;
      end
    endcase
    if (next_s.jump && !next_s.resume) begin
      next_s.cur_pri = win;
      next_s.jsrc    = win;
      next_s.jfile   = (win == 4'h0) ? s.ffile : 8'h00;
      next_s.jrung   = 16'h0000;
      next_s.pending = next_s.pending & ~(16'h0001 << win);
      irq_ev[scis_pkg::IRQ_DISPATCH] = 1'b1;
      if (win == 4'h0) begin
        next_s.saved = arith_flags;
      end
    end
    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    if (wr) begin
      unique case (paddr)
        scis_pkg::ADDR_CONFIG:  next_s.cfg    = pwdata[15:0];
        scis_pkg::ADDR_DISABLE: next_s.dis    = pwdata[15:0] & scis_pkg::DISABLE_USED;
        scis_pkg::ADDR_FFILE:   next_s.ffile  = pwdata[7:0];
        scis_pkg::ADDR_IRQ_EN:  next_s.irq_en = pwdata[2:0];
        default: ;
      endcase
    end
    next_s.irq_st = irq_ev | (s.irq_st &
                    ~((wr && paddr == scis_pkg::ADDR_IRQ_CLEAR) ? pwdata[2:0] : 3'h0));
    if (rd) begin
      unique case (paddr)
        scis_pkg::ADDR_CONFIG:   next_s.rdata = {16'h0000, s.cfg};
        scis_pkg::ADDR_DISABLE:  next_s.rdata = {16'h0000, s.dis};
        scis_pkg::ADDR_FFILE:    next_s.rdata = {24'h00_0000, s.ffile};
        scis_pkg::ADDR_PENDING:  next_s.rdata = {16'h0000, s.pending};
        scis_pkg::ADDR_STATUS:   next_s.rdata = {12'h000, s.halted, s.shutdown, s.major,
                                                 s.recov, 2'h0, s.st, 3'h0, s.sp,
                                                 s.cur_pri};
        scis_pkg::ADDR_IRQ_STAT: next_s.rdata = {29'h0000_0000, s.irq_st};
        scis_pkg::ADDR_IRQ_EN:   next_s.rdata = {29'h0000_0000, s.irq_en};
        scis_pkg::ADDR_ARITH:    next_s.rdata = {16'h0000, s.saved};
        default:                 next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s        <= '0;
      s.st     <= scis_pkg::ST_NORMAL;
      s.cfg    <= scis_pkg::CONFIG_RESET;
      s.dis    <= scis_pkg::DISABLE_RESET;
      s.ffile  <= scis_pkg::FFILE_RESET;
      s.irq_en <= scis_pkg::IRQ_EN_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && !(paddr inside {scis_pkg::ADDR_CONFIG,
                         scis_pkg::ADDR_DISABLE, scis_pkg::ADDR_FFILE,
                         scis_pkg::ADDR_PENDING, scis_pkg::ADDR_STATUS,
                         scis_pkg::ADDR_IRQ_STAT, scis_pkg::ADDR_IRQ_CLEAR,
                         scis_pkg::ADDR_IRQ_EN, scis_pkg::ADDR_ARITH});
  assign prdata        = s.rdata;
  assign irq           = |(s.irq_st & s.irq_en);
  assign jump          = s.jump;
  assign jump_resume   = s.resume;
  assign jump_src      = s.jsrc;
  assign jump_file     = s.jfile;
  assign jump_rung     = s.jrung;
  assign arith_restore = s.arest;
  assign arith_value   = s.aval;
  assign halted        = s.halted;
  assign shutdown      = s.shutdown;
  assign major_fault   = s.major;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_dispatch;
    jump && !jump_resume;
  endsequence

  a_dispatch_at_point: assert property (seq_dispatch |-> $past(svc))
    else $error("dispatch outside a service point");
  a_dispatch_enabled: assert property (seq_dispatch |->
    ($past(cand) & (16'h0001 << jump_src)) != 16'h0000)
    else $error("dispatched source not configured and enabled");
  a_dispatch_order: assert property (seq_dispatch |->
    ($past(cand) & ((16'h0001 << jump_src) - 16'h0001)) == 16'h0000)
    else $error("higher priority request skipped");
  a_rung_zero: assert property (seq_dispatch |-> jump_rung == 16'h0000)
    else $error("handler not started at rung 0");
  a_preempt_higher: assert property (
    seq_dispatch and ($past(s.sp) != 5'h00 && $past(s.st) != scis_pkg::ST_POP)
    |-> jump_src < $past(s.cur_pri))
    else $error("preemption by a lower priority source");
  a_pending_cleared: assert property (seq_dispatch |->
    !s.pending[jump_src] || ($past(s.arrived) & (16'h0001 << jump_src)) != 16'h0000)
    else $error("pending bit survives its dispatch");
  a_fault_file: assert property (seq_dispatch and (jump_src == 4'h0) |->
    jump_file == s.ffile && jump_file >= scis_pkg::FFILE_MIN)
    else $error("fault handler file not from selector");
  a_arith_restore: assert property (arith_restore |-> arith_value == s.saved)
    else $error("restored flags differ from saved flags");
  a_nonuser_halt: assert property (
    fault_req && fault_class == scis_pkg::CLASS_NONUSER |=> halted ##1 !jump)
    else $error("non-user fault did not halt");

endmodule

// ---- core/scis_pkg.sv ----
// constants, state codes and helpers shared by the scan interrupt scheduler
// assumes one controller clock and an APB register port
package scis_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG    = 8'h00;
  localparam logic [7:0] ADDR_DISABLE   = 8'h04;
  localparam logic [7:0] ADDR_FFILE     = 8'h08;
  localparam logic [7:0] ADDR_PENDING   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h1C;
  localparam logic [7:0] ADDR_ARITH     = 8'h20;

  // ----------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [15:0] CONFIG_RESET  = 16'h0000;
  localparam logic [15:0] DISABLE_RESET = 16'h0000;
  localparam logic [15:0] DISABLE_USED  = 16'h7FFF;
  localparam logic [7:0]  FFILE_RESET   = 8'h00;
  localparam logic [7:0]  FFILE_MIN     = 8'h03;
  localparam logic [2:0]  IRQ_EN_RESET  = 3'h0;
  localparam int          NSRC          = 16;
  localparam int          IRQ_W         = 3;
  localparam int          IRQ_DISPATCH  = 0;
  localparam int          IRQ_HALT      = 1;
  localparam int          IRQ_SHUTDOWN  = 2;
  localparam int          CTX_W         = 28;

  // fault classes on the fault port
  localparam logic [1:0] CLASS_RECOV   = 2'h0;
  localparam logic [1:0] CLASS_NONREC  = 2'h1;
  localparam logic [1:0] CLASS_NONUSER = 2'h2;

  typedef enum logic [1:0] {
    ST_NORMAL  = 2'b00,
    ST_HANDLER = 2'b01,
    ST_POP     = 2'b10
  } scis_state_type;

  // ----------------------------------------------------------------
  // disable mask bit of a source given by its priority level
  // ----------------------------------------------------------------
  function automatic logic [3:0] scis_mask_bit(input logic [3:0] pri);
    logic [3:0] b;
    b = (pri < 4'h8) ? 4'(4'h7 - pri) : 4'(5'h16 - {1'b0, pri});
    return b;
  endfunction

endpackage

// ---- core/scis_prio_enc.sv ----
// fixed priority picker, bit 0 is the highest level
// assumes requests are already gated by configuration and enable
`timescale 1ns/1ps
module scis_prio_enc #(
  parameter int N = 16
) (
  input  wire logic [N-1:0]         req,
  output logic                      valid,
  output logic [$clog2(N)-1:0]      idx
);

  always_comb begin
    valid = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        valid = 1'b1;
        idx   = ($clog2(N))'(i);
      end
    end
  end

endmodule

// ---- core/scis_ctx_stack.sv ----
// memory of suspended contexts, registered read port
// assumes write and read addresses are managed by the scheduler
`timescale 1ns/1ps
module scis_ctx_stack #(
  parameter int W     = 28,
  parameter int DEPTH = 16
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [W-1:0]             wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [W-1:0]                  rd_data
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ---- sim/scis_exec_model.sv ----
// ladder program executor seen from the scheduler: rung starts and current point
// assumes jump and its data stand for one cycle, as the scheduler drives them
`timescale 1ns/1ps
module scis_exec_model #(
  parameter int GAP = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic        jump,
  input  wire logic        jump_resume,
  input  wire logic [3:0]  jump_src,
  input  wire logic [7:0]  jump_file,
  input  wire logic [15:0] jump_rung,
  output logic             rung_start,
  output logic [7:0]       cur_file,
  output logic [15:0]      cur_rung
);
  // ----------------------------------------------------------------
  // rung stepping and jumps
  // ----------------------------------------------------------------
  logic [7:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt        <= 8'h00;
      rung_start <= 1'b0;
      cur_file   <= 8'h02;
      cur_rung   <= 16'h0005;
    end else begin
      rung_start <= run && (cnt == 8'(GAP - 1));
      cnt        <= (cnt == 8'(GAP - 1)) ? 8'h00 : cnt + 8'h01;
      if (jump) begin
        cur_file <= (jump_resume || jump_file != 8'h00) ? jump_file : 8'h10 + {4'h0, jump_src};
        cur_rung <= jump_rung;
      end else if (rung_start) begin
        cur_rung <= cur_rung + 16'h0001;
      end
    end
  end
endmodule

// ---- sim/scis_scheduler_tb_top.sv ----
// self-checking bench of the scan interrupt scheduler
// assumes the executor model and an apb master made of tasks
`timescale 1ns/1ps
module scis_scheduler_tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, err;
  logic        fault_req = 1'b0;
  logic [1:0]  fault_class = 2'h0;
  logic        fault_clear = 1'b0;
  logic [15:0] arith = 16'h0000;
  logic [7:0]  ev = 8'h00;
  logic [5:0]  ctr = 6'h00;
  logic        tim = 1'b0;
  logic        eos = 1'b0;
  logic        hd = 1'b0;
  logic        run = 1'b0;
  logic        rung_start, jump, jump_resume, arith_restore, halted, shutdown, major_fault;
  logic [7:0]  cur_file, jump_file;
  logic [15:0] cur_rung, jump_rung, arith_value;
  logic [3:0]  jump_src;
  int          fails = 0;
  int          checked = 0;

  always #4 pclk = ~pclk;

  scis_scheduler dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .fault_req(fault_req), .fault_class(fault_class),
    .fault_clear(fault_clear), .arith_flags(arith), .event_input_interrupt(ev),
    .fast_counter_interrupt(ctr), .periodic_timed_interrupt(tim), .rung_start(rung_start),
    .end_of_scan(eos), .handler_done(hd), .cur_file(cur_file), .cur_rung(cur_rung),
    .jump(jump), .jump_resume(jump_resume), .jump_src(jump_src), .jump_file(jump_file),
    .jump_rung(jump_rung), .arith_restore(arith_restore), .arith_value(arith_value),
    .halted(halted), .shutdown(shutdown), .major_fault(major_fault));

  scis_exec_model #(.GAP(4)) exec (.pclk(pclk), .presetn(presetn), .run(run), .jump(jump),
    .jump_resume(jump_resume), .jump_src(jump_src), .jump_file(jump_file),
    .jump_rung(jump_rung), .rung_start(rung_start), .cur_file(cur_file), .cur_rung(cur_rung));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input logic [7:0] e, input logic [5:0] c, input logic t);
    @(posedge pclk);
    ev <= e;
    ctr <= c;
    tim <= t;
    @(posedge pclk);
    ev <= 8'h00;
    ctr <= 6'h00;
    tim <= 1'b0;
  endtask

  task automatic fpulse(input logic [1:0] c);
    @(posedge pclk);
    fault_req <= 1'b1;
    fault_class <= c;
    @(posedge pclk);
    fault_req <= 1'b0;
  endtask

  task automatic eos_pulse;
    @(posedge pclk);
    eos <= 1'b1;
    @(posedge pclk);
    eos <= 1'b0;
  endtask

  task automatic done;
    @(posedge pclk);
    hd <= 1'b1;
    @(posedge pclk);
    hd <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic wj(input logic [3:0] s, input logic res, input logic cs);
    int n;
    n = 0;
    do begin @(negedge pclk); n++; end while (jump !== 1'b1 && n < 60);
    chk(32'(jump), 32'h0000_0001);
    chk(32'(jump_resume), 32'(res));
    if (cs) chk(32'(jump_src), 32'(s));
  endtask

  task automatic nojump(input int n);
    int k;
    k = 0;
    repeat (n) begin @(negedge pclk); if (jump !== 1'b0) k++; end
    chk(32'(k), 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, scis_pkg::ADDR_CONFIG, 32'h0); chk(rd, 32'(scis_pkg::CONFIG_RESET));
    apb(1'b0, scis_pkg::ADDR_FFILE, 32'h0); chk(rd, 32'(scis_pkg::FFILE_RESET));
    apb(1'b0, scis_pkg::ADDR_IRQ_EN, 32'h0); chk(rd, 32'(scis_pkg::IRQ_EN_RESET));
    apb(1'b1, scis_pkg::ADDR_DISABLE, 32'h0000_FFFF);
    apb(1'b0, scis_pkg::ADDR_DISABLE, 32'h0); chk(rd, 32'h0000_7FFF);
    apb(1'b1, scis_pkg::ADDR_DISABLE, 32'h0);
    apb(1'b0, 8'h40, 32'h0); chk(32'(err), 32'h1); chk(rd, 32'h0);
    apb(1'b1, scis_pkg::ADDR_PENDING, 32'h0000_FFFF);
    apb(1'b0, scis_pkg::ADDR_PENDING, 32'h0); chk(rd, 32'h0);
  endtask

  task automatic t_dispatch;
    logic [7:0]  f;
    logic [15:0] r;
    apb(1'b1, scis_pkg::ADDR_CONFIG, 32'h0000_FFFF);
    apb(1'b1, scis_pkg::ADDR_IRQ_EN, 32'h0000_0001);
    f = cur_file;
    r = cur_rung;
    pulse(8'h01, 6'h00, 1'b0);
    nojump(10);
    eos_pulse;
    wj(4'h1, 1'b0, 1'b1);
    chk(32'(jump_rung), 32'h0);
    apb(1'b0, scis_pkg::ADDR_PENDING, 32'h0); chk(rd, 32'h0);
    apb(1'b1, scis_pkg::ADDR_IRQ_EN, 32'h0); @(negedge pclk); chk(32'(irq), 32'h0);
    apb(1'b1, scis_pkg::ADDR_IRQ_EN, 32'h1); @(negedge pclk); chk(32'(irq), 32'h1);
    apb(1'b1, scis_pkg::ADDR_IRQ_CLEAR, 32'h1); @(negedge pclk); chk(32'(irq), 32'h0);
    done;
    wj(4'h0, 1'b1, 1'b0);
    chk(32'(jump_file), 32'(f));
    chk(32'(jump_rung), 32'(r));
  endtask

  task automatic t_order;
    pulse(8'hFF, 6'h3F, 1'b1);
    @(posedge pclk);
    eos <= 1'b1;
    for (int l = 1; l < 16; l++) begin
      wj(4'(l), 1'b0, 1'b1);
      done;
    end
    wj(4'h0, 1'b1, 1'b0);
    @(posedge pclk);
    eos <= 1'b0;
  endtask

  task automatic t_disabled;
    apb(1'b1, scis_pkg::ADDR_DISABLE, 32'h0000_0040);
    pulse(8'h01, 6'h00, 1'b0);
    eos_pulse;
    nojump(10);
    apb(1'b0, scis_pkg::ADDR_PENDING, 32'h0); chk(rd, 32'h0000_0002);
    apb(1'b1, scis_pkg::ADDR_DISABLE, 32'h0);
    apb(1'b1, scis_pkg::ADDR_CONFIG, 32'h0000_FFFD);
    eos_pulse;
    nojump(10);
    apb(1'b1, scis_pkg::ADDR_CONFIG, 32'h0000_FFFF);
    eos_pulse;
    wj(4'h1, 1'b0, 1'b1);
    done;
    wj(4'h0, 1'b1, 1'b0);
    apb(1'b0, scis_pkg::ADDR_PENDING, 32'h0); chk(rd, 32'h0);
  endtask

  task automatic t_nest;
    pulse(8'h00, 6'h01, 1'b0);
    eos_pulse;
    wj(4'h3, 1'b0, 1'b1);
    pulse(8'h81, 6'h00, 1'b0);
    run <= 1'b1;
    wj(4'h1, 1'b0, 1'b1);
    @(posedge pclk);
    run <= 1'b0;
    done;
    wj(4'h3, 1'b1, 1'b1);
    done;
    wj(4'he, 1'b0, 1'b1);
    done;
    wj(4'h0, 1'b1, 1'b0);
  endtask

  task automatic t_fault;
    @(posedge pclk);
    arith <= 16'h1234;
    apb(1'b1, scis_pkg::ADDR_FFILE, 32'h0000_0002);
    fpulse(scis_pkg::CLASS_RECOV);
    eos_pulse;
    nojump(10);
    apb(1'b1, scis_pkg::ADDR_FFILE, 32'h0000_0020);
    eos_pulse;
    wj(4'h0, 1'b0, 1'b1);
    chk(32'(jump_file), 32'h0000_0020);
    chk(32'(major_fault), 32'h1);
    apb(1'b0, scis_pkg::ADDR_ARITH, 32'h0); chk(rd, 32'h0000_1234);
    @(posedge pclk);
    arith <= 16'h5555;
    fault_clear <= 1'b1;
    @(posedge pclk);
    fault_clear <= 1'b0;
    done;
    chk(32'(arith_restore), 32'h1);
    chk(32'(arith_value), 32'h0000_1234);
    chk(32'(shutdown), 32'h0);
    wj(4'h0, 1'b1, 1'b0);
    fpulse(scis_pkg::CLASS_NONREC);
    eos_pulse;
    wj(4'h0, 1'b0, 1'b1);
    done;
    chk(32'(shutdown), 32'h1);
    repeat (4) @(posedge pclk);
    fpulse(scis_pkg::CLASS_NONUSER);
    eos_pulse;
    nojump(10);
    chk(32'(halted), 32'h1);
    apb(1'b0, scis_pkg::ADDR_STATUS, 32'h0); chk(rd, 32'h000E_0000);
    apb(1'b0, scis_pkg::ADDR_IRQ_STAT, 32'h0); chk(rd, 32'h0000_0007);
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_dispatch;
    t_order;
    t_disabled;
    t_nest;
    t_fault;
    conclude;
  end

  initial begin
    #200000;
    fails++;
    conclude;
  end
endmodule
